//--- mgmt_filter_params.svh
// register offsets, field positions and reset values of the filter block
`ifndef MGMT_FILTER_PARAMS_SVH
`define MGMT_FILTER_PARAMS_SVH

// register numbers on the management page (16-bit registers)
`define REG_LOW24_LO 8'h2c
`define REG_LOW24_HI 8'h2d
`define REG_BIND_LO 8'h32
`define REG_BIND_HI 8'h33
`define REG_SHR_EN 8'h34
`define REG_V4_LO 8'h50
`define REG_V4_HI 8'h51

// binding control field positions
`define BIND_TCP9 9
`define BIND_TCP10 10
`define BIND_RSVD_LO 11
`define BIND_UDP0 12
`define BIND_DHCP6 13
`define BIND_EAP 14
`define BIND_DNS 15
`define BIND_FLEX_LSB 16
`define BIND_RANGE 28
`define BIND_ICMP6 29
`define BIND_RSVD_HI 30
`define BIND_RMCP 31

// writable bit masks (reserved and read-only bits excluded)
`define BIND_WR_MASK_LO 16'hd7ff
`define BIND_WR_MASK_HI 16'hbfff
`define SHR_EN_MASK 16'h07ff

// reset values
`define BIND_RST 32'h0000_0000
`define SHR_EN_RST 16'h0000
`define V4_RST 32'h0000_0000
`define LOW24_RST 24'h00_0000

`endif

//--- mgmt_filter_pkg.sv
// types shared by the management filter block and its users
package mgmt_filter_pkg;

  typedef logic [10:0][47:0] mac_table_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
  } reg_rsp_t;

  // one received packet, already parsed; v4_dst[0] is first on the wire
  typedef struct packed {
    logic valid;
    logic [47:0] dst_mac;
    logic is_ipv6;
    logic [23:0] v6_low24;
    logic is_ipv4;
    logic is_arp;
    logic [3:0][7:0] v4_dst;
    logic [10:0] tcp_hit;
    logic udp0_hit;
    logic dhcp6_hit;
    logic eap_hit;
    logic dns_hit;
    logic [11:0] flex_hit;
    logic range_hit;
    logic icmp6_hit;
    logic rmcp_hit;
  } rx_meta_t;

  // pass is aligned with the binding control bit positions
  typedef struct packed {
    logic valid;
    logic [31:0] pass;
    logic low24_match;
    logic [10:0] slot_hit;
    logic to_fw;
    logic v4_arp_match;
    logic v4_wake_match;
  } verdict_t;

  typedef struct packed {
    logic [31:0] bind_reg;
    logic [15:0] shr_en_reg;
    logic [31:0] v4_reg;
    logic [23:0] low24_reg;
    reg_rsp_t rsp;
    verdict_t verdict;
  } state_t;

endpackage

//--- mgmt_ip_filter_binding.sv
// management receive filter binding, shared address routing, ipv4 entry
`timescale 1ns/10ps
`default_nettype none
`include "mgmt_filter_params.svh"

module mgmt_ip_filter_binding (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // management register access
  input wire mgmt_filter_pkg::reg_req_t reg_req,
  output mgmt_filter_pkg::reg_rsp_t reg_rsp,
  // hardware-owned read-only binding of the dhcpv6 filter
  input wire logic addr_config_v6_bind_en,
  // shared address table kept elsewhere
  input wire mgmt_filter_pkg::mac_table_t shared_mac_slot,
  input wire logic [10:0] address_valid_flag,
  // parsed receive packet and its filter verdict
  input wire mgmt_filter_pkg::rx_meta_t rx,
  output mgmt_filter_pkg::verdict_t verdict
);
  import mgmt_filter_pkg::*;

  state_t st_reg;
  state_t st_next;
  logic [10:0] slot_match;
  logic [3:0] v4_byte_eq;

  // full 48-bit compare per slot, gated by enable and valid flag
  genvar gi;
  generate
    for (gi = 0; gi < 11; gi = gi + 1) begin : g_slot
      assign slot_match[gi] = st_reg.shr_en_reg[gi] &
        address_valid_flag[gi] &
        (rx.dst_mac == shared_mac_slot[gi]);
    end
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_v4
      // entry byte gi meets wire byte gi, low byte first
      assign v4_byte_eq[gi] =
        (st_reg.v4_reg[8*gi +: 8] == rx.v4_dst[gi]);
    end
  endgenerate

  always_comb begin
    logic [31:0] hit;
    logic low24;
    hit = 32'h0000_0000;
    low24 = 1'b0;
    st_next = st_reg;

    // register writes; reserved bits are masked, bit 13 is hardware-owned
    if (reg_req.wr) begin
      case (reg_req.addr)
        `REG_BIND_LO: begin
          st_next.bind_reg[15:0] = reg_req.wdata & `BIND_WR_MASK_LO;
        end
        `REG_BIND_HI: begin
          st_next.bind_reg[31:16] = reg_req.wdata & `BIND_WR_MASK_HI;
        end
        `REG_SHR_EN: begin
          st_next.shr_en_reg = reg_req.wdata & `SHR_EN_MASK;
        end
        `REG_V4_LO: begin
          st_next.v4_reg[15:0] = reg_req.wdata;
        end
        `REG_V4_HI: begin
          st_next.v4_reg[31:16] = reg_req.wdata;
        end
        `REG_LOW24_LO: begin
          st_next.low24_reg[15:0] = reg_req.wdata;
        end
        `REG_LOW24_HI: begin
          st_next.low24_reg[23:16] = reg_req.wdata[7:0];
        end
        default: begin
        end
      endcase
    end
    st_next.bind_reg[`BIND_DHCP6] = addr_config_v6_bind_en;

    // reads answer one cycle later; unmapped numbers read zero
    st_next.rsp.ack = reg_req.rd | reg_req.wr;
    st_next.rsp.rdata = 16'h0000;
    if (reg_req.rd) begin
      case (reg_req.addr)
        `REG_BIND_LO: begin
          st_next.rsp.rdata = st_reg.bind_reg[15:0];
        end
        `REG_BIND_HI: begin
          st_next.rsp.rdata = st_reg.bind_reg[31:16];
        end
        `REG_SHR_EN: begin
          st_next.rsp.rdata = st_reg.shr_en_reg;
        end
        `REG_V4_LO: begin
          st_next.rsp.rdata = st_reg.v4_reg[15:0];
        end
        `REG_V4_HI: begin
          st_next.rsp.rdata = st_reg.v4_reg[31:16];
        end
        `REG_LOW24_LO: begin
          st_next.rsp.rdata = st_reg.low24_reg[15:0];
        end
        `REG_LOW24_HI: begin
          st_next.rsp.rdata = {8'h00, st_reg.low24_reg[23:16]};
        end
        default: begin
        end
      endcase
    end

    // only ipv6 packets can satisfy the low-24 filter
    low24 = rx.is_ipv6 && (rx.v6_low24 == st_reg.low24_reg);
    hit = {rx.rmcp_hit, 1'b0, rx.icmp6_hit, rx.range_hit, rx.flex_hit,
      rx.dns_hit, rx.eap_hit, rx.dhcp6_hit, rx.udp0_hit, 1'b0, rx.tcp_hit};

    st_next.verdict.valid = rx.valid;
    st_next.verdict.low24_match = rx.valid & low24;
    // a bound filter also needs the address match; unbound ones stand alone
    st_next.verdict.pass = {32{rx.valid}} & hit &
      ~(st_reg.bind_reg & {32{~low24}});
    st_next.verdict.slot_hit = {11{rx.valid}} & slot_match;
    st_next.verdict.to_fw = rx.valid & (|slot_match);
    // one entry feeds both the request matcher and the wake matcher
    st_next.verdict.v4_arp_match = rx.valid & rx.is_arp & (&v4_byte_eq);
    st_next.verdict.v4_wake_match =
      rx.valid & rx.is_ipv4 & (&v4_byte_eq);
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
      st_reg.bind_reg <= `BIND_RST;
      st_reg.shr_en_reg <= `SHR_EN_RST;
      st_reg.v4_reg <= `V4_RST;
      st_reg.low24_reg <= `LOW24_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rsp = st_reg.rsp;
  assign verdict = st_reg.verdict;

  // checks on the verdict and the register file
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  logic no_low24;
  assign no_low24 = !(rx.is_ipv6 && (rx.v6_low24 == st_reg.low24_reg));

  sequence bound_miss(int b);
    rx.valid && st_reg.bind_reg[b] && no_low24;
  endsequence

  sequence shr_write_ones;
    reg_req.wr && !reg_req.rd && reg_req.addr == `REG_SHR_EN &&
      reg_req.wdata == 16'hffff;
  endsequence

  sequence shr_read;
    reg_req.rd && !reg_req.wr && reg_req.addr == `REG_SHR_EN;
  endsequence

  sequence shr_idle;
    !reg_req.wr && !reg_req.rd;
  endsequence

  tcp_bind_block_a: assert property (
    bound_miss(`BIND_TCP9) or bound_miss(`BIND_TCP10) |=>
      !(verdict.pass[`BIND_TCP9] && $past(st_reg.bind_reg[`BIND_TCP9])) &&
      !(verdict.pass[`BIND_TCP10] && $past(st_reg.bind_reg[`BIND_TCP10])))
    else $error("bound tcp filter passed without address match");

  udp0_bind_block_a: assert property (
    bound_miss(`BIND_UDP0) |=> !verdict.pass[`BIND_UDP0])
    else $error("bound udp port 0 filter passed without address match");

  dhcp_bind_block_a: assert property (
    rx.valid && st_reg.bind_reg[`BIND_DHCP6] &&
      no_low24 |=> !verdict.pass[`BIND_DHCP6])
    else $error("bound dhcpv6 filter passed without address match");

  eap_bind_block_a: assert property (
    bound_miss(`BIND_EAP) |=> !verdict.pass[`BIND_EAP])
    else $error("bound eap filter passed without address match");

  dns_bind_block_a: assert property (
    bound_miss(`BIND_DNS) |=> !verdict.pass[`BIND_DNS])
    else $error("bound dns filter passed without address match");

  flex_bind_block_a: assert property (
    rx.valid && no_low24 |=> (verdict.pass[27:16] &
      $past(st_reg.bind_reg[27:16])) == 12'h000)
    else $error("bound flex filter passed without address match");

  range_bind_block_a: assert property (
    bound_miss(`BIND_RANGE) |=> !verdict.pass[`BIND_RANGE])
    else $error("bound port range filter passed without address match");

  icmp_bind_block_a: assert property (
    bound_miss(`BIND_ICMP6) |=> !verdict.pass[`BIND_ICMP6])
    else $error("bound icmpv6 filter passed without address match");

  rmcp_bind_block_a: assert property (
    bound_miss(`BIND_RMCP) |=> !verdict.pass[`BIND_RMCP])
    else $error("bound rmcp filter passed without address match");

  bind_rsvd_zero_a: assert property (
    reg_req.rd && reg_req.addr == `REG_BIND_LO |=>
      !reg_rsp.rdata[`BIND_RSVD_LO] && reg_rsp.ack)
    else $error("reserved binding bit read nonzero");

  unbound_passes_a: assert property (
    rx.valid && !st_reg.bind_reg[`BIND_DNS] |=>
      verdict.pass[`BIND_DNS] == $past(rx.dns_hit))
    else $error("unbound dns filter not decided by its own hit");

  slot_route_fw_a: assert property (
    rx.valid && st_reg.shr_en_reg[3] && address_valid_flag[3] &&
      rx.dst_mac == shared_mac_slot[3] |=>
      verdict.to_fw && verdict.slot_hit[3])
    else $error("enabled valid matching slot not routed to firmware");

  slot_mac_full_a: assert property (
    rx.valid && rx.dst_mac != shared_mac_slot[0] |=> !verdict.slot_hit[0])
    else $error("slot hit without full address match");

  shr_en_readback_a: assert property (
    shr_write_ones ##1 shr_idle ##1 shr_read |=>
      reg_rsp.rdata == `SHR_EN_MASK)
    else $error("shared enable readback wrong or reserved bits set");

  v4_wake_match_a: assert property (
    rx.valid && rx.is_ipv4 && rx.v4_dst[0] == st_reg.v4_reg[7:0] &&
      rx.v4_dst[1] == st_reg.v4_reg[15:8] &&
      rx.v4_dst[2] == st_reg.v4_reg[23:16] &&
      rx.v4_dst[3] == st_reg.v4_reg[31:24] |=> verdict.v4_wake_match)
    else $error("directed ipv4 wake match missed");

  low24_compare_a: assert property (
    rx.valid && !rx.is_ipv6 |=> !verdict.low24_match)
    else $error("low-24 match on a non-ipv6 packet");

  low24_hit_a: assert property (
    rx.valid && rx.is_ipv6 && rx.v6_low24 == st_reg.low24_reg |=>
      verdict.low24_match)
    else $error("matching ipv6 low-24 address not flagged");

  flex_bound_hit_a: assert property (
    rx.valid && !no_low24 |=> verdict.pass[27:16] == $past(rx.flex_hit))
    else $error("flex filter blocked despite an address match");

  unbound_tcp_a: assert property (
    rx.valid && !st_reg.bind_reg[`BIND_TCP9] |=>
      verdict.pass[`BIND_TCP9] == $past(rx.tcp_hit[`BIND_TCP9]))
    else $error("unbound tcp filter 9 not decided by its own hit");

  dhcp_bit_follow_a: assert property (
    $past(arst_n) |->
      st_reg.bind_reg[`BIND_DHCP6] == $past(addr_config_v6_bind_en))
    else $error("read-only dhcpv6 binding bit does not track its input");

  bind_hi_rsvd_a: assert property (
    reg_req.rd && reg_req.addr == `REG_BIND_HI |=>
      !reg_rsp.rdata[`BIND_RSVD_HI - 16] && reg_rsp.ack)
    else $error("reserved upper binding bit read nonzero");

  shr_rsvd_zero_a: assert property (
    shr_read |=> reg_rsp.rdata[15:11] == 5'h00)
    else $error("reserved shared enable bits read nonzero");

  slot_needs_en_a: assert property (
    rx.valid && !st_reg.shr_en_reg[10] |=> !verdict.slot_hit[10])
    else $error("slot routed while its enable bit is clear");

  slot_needs_valid_a: assert property (
    rx.valid && !address_valid_flag[10] |=> !verdict.slot_hit[10])
    else $error("slot routed while its address is not valid");

  // whole-word compare, relying on wire byte 0 sitting lowest in the word
  logic v4_entry_hit;
  assign v4_entry_hit = (rx.v4_dst == st_reg.v4_reg);

  v4_arp_hit_a: assert property (
    rx.valid && rx.is_arp && v4_entry_hit |=> verdict.v4_arp_match)
    else $error("arp request to the management address missed");

  v4_order_miss_a: assert property (
    rx.valid && rx.is_ipv4 && !v4_entry_hit |=> !verdict.v4_wake_match)
    else $error("wake match on another ipv4 address");

endmodule
`default_nettype wire

//--- rx_source.sv
// receive packet source standing in for the phy packet parser
`timescale 1ns/10ps
`default_nettype none
module rx_source (
  // clock
  input wire logic ref_clk,
  // parsed packet descriptor
  output var mgmt_filter_pkg::rx_meta_t rx
);
  import mgmt_filter_pkg::*;
  initial begin
    rx = '1;
    rx.valid = 1'b0;
  end
  // fields flip once released so a stale descriptor never looks live
  task automatic send(input rx_meta_t m);
    @(negedge ref_clk);
    rx = m;
    rx.valid = 1'b1;
    @(negedge ref_clk);
    rx = ~m;
    rx.valid = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- tb.sv
// self-checking bench for the management filter binding block
`timescale 1ns/10ps
`default_nettype none
`include "mgmt_filter_params.svh"
module tb;
  import mgmt_filter_pkg::*;
  typedef struct packed {
    logic [31:0] bind_val;
    logic [23:0] low;
    logic is6;
    logic [31:0] exp_pass;
    logic exp_l24;
  } row_t;
  localparam logic [31:0] HIT_ALL = 32'hbfff_f7ff;
  localparam logic [23:0] L24 = 24'h12_3456;
  localparam logic [23:0] BAD24 = 24'h12_3457;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  reg_req_t reg_req = '0;
  reg_rsp_t reg_rsp;
  logic addr_config_v6_bind_en = 1'b0;
  mac_table_t shared_mac_slot;
  logic [10:0] address_valid_flag = 11'h000;
  rx_meta_t rx;
  verdict_t verdict;
  int failures = 0;
  int n_checks = 0;
  logic [15:0] rd_data;
  rx_meta_t m;
  logic [1:0] v4m;
  logic [7:0] map [7] = '{8'h2c, 8'h2d, 8'h32, 8'h33, 8'h34, 8'h50, 8'h51};
  row_t rows [8] = '{
    '{32'h0, L24, 1'b1, HIT_ALL, 1'b1},
    '{32'h0, BAD24, 1'b1, HIT_ALL, 1'b0},
    '{32'hffff_ffff, 24'h92_3456, 1'b1, 32'h0, 1'b0},
    '{32'hffff_ffff, L24, 1'b1, HIT_ALL, 1'b1},
    '{32'hffff_ffff, L24, 1'b0, 32'h0, 1'b0},
    '{32'h0000_0600, BAD24, 1'b1, 32'hbfff_f1ff, 1'b0},
    '{32'h0000_f000, BAD24, 1'b1, 32'hbfff_07ff, 1'b0},
    '{32'hffff_0000, BAD24, 1'b1, 32'h0000_f7ff, 1'b0}};
  always #20 ref_clk = ~ref_clk;
  mgmt_ip_filter_binding u_mgmt_ip_filter_binding (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .reg_req(reg_req),
    .reg_rsp(reg_rsp),
    .addr_config_v6_bind_en(addr_config_v6_bind_en),
    .shared_mac_slot(shared_mac_slot),
    .address_valid_flag(address_valid_flag),
    .rx(rx),
    .verdict(verdict));
  rx_source u_rx_source (.ref_clk(ref_clk), .rx(rx));
  assign v4m = {verdict.v4_arp_match, verdict.v4_wake_match};
  task automatic summarize();
    if (failures == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // ack is fixed at one cycle, so no polling is needed
  task automatic reg_op(input logic w, input logic [7:0] a,
                        input logic [15:0] d);
    @(negedge ref_clk);
    reg_req.wr = w;
    reg_req.rd = ~w;
    reg_req.addr = a;
    reg_req.wdata = d;
    @(negedge ref_clk);
    reg_req = '0;
    chk({31'h0, reg_rsp.ack}, 32'h1, "ack");
    rd_data = reg_rsp.rdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    reg_op(1'b0, a, 16'h0);
    chk({16'h0, rd_data}, {16'h0, exp}, "read");
  endtask
  task automatic route(input logic [10:0] flag, input logic [47:0] dst,
                       input logic exp);
    address_valid_flag = flag;
    m = '0;
    m.dst_mac = dst;
    u_rx_source.send(m);
    chk({31'h0, verdict.to_fw}, {31'h0, exp}, "to_fw");
  endtask
  initial begin
    #(40 * 4000);
    failures++;
    summarize();
  end
  initial begin
    for (int n = 0; n < 11; n++) begin
      shared_mac_slot[n] = 48'h0200_0000_0000 + 48'(n);
    end
    repeat (10) @(negedge ref_clk);
    arst_n = 1'b1;
    foreach (map[i]) rd_chk(map[i], 16'h0);
    reg_op(1'b1, 8'h40, 16'hffff);
    rd_chk(8'h40, 16'h0);
    reg_op(1'b1, `REG_LOW24_LO, L24[15:0]);
    reg_op(1'b1, `REG_LOW24_HI, {8'h0, L24[23:16]});
    rd_chk(`REG_LOW24_HI, 16'h0012);
    foreach (rows[i]) begin
      addr_config_v6_bind_en = rows[i].bind_val[13];
      reg_op(1'b1, `REG_BIND_LO, rows[i].bind_val[15:0]);
      reg_op(1'b1, `REG_BIND_HI, rows[i].bind_val[31:16]);
      rd_chk(`REG_BIND_LO, rows[i].bind_val[15:0] & HIT_ALL[15:0]);
      rd_chk(`REG_BIND_HI, rows[i].bind_val[31:16] & HIT_ALL[31:16]);
      m = '1;
      m.is_ipv4 = 1'b0;
      m.is_arp = 1'b0;
      m.is_ipv6 = rows[i].is6;
      m.v6_low24 = rows[i].low;
      u_rx_source.send(m);
      chk({31'h0, verdict.valid}, 32'h1, "valid");
      chk(verdict.pass, rows[i].exp_pass, "pass");
      chk(verdict.pass >> 16, rows[i].exp_pass >> 16, "hi");
      chk({31'h0, verdict.low24_match}, {31'h0, rows[i].exp_l24}, "l");
    end
    reg_op(1'b1, `REG_SHR_EN, 16'hffff);
    rd_chk(`REG_SHR_EN, 16'h07ff);
    route(11'h400, shared_mac_slot[10], 1'b1);
    chk({21'h0, verdict.slot_hit}, 32'h400, "slot");
    route(11'h400, shared_mac_slot[10] ^ 48'h8000_0000_0000, 1'b0);
    route(11'h3ff, shared_mac_slot[10], 1'b0);
    reg_op(1'b1, `REG_SHR_EN, 16'h03ff);
    route(11'h7ff, shared_mac_slot[10], 1'b0);
    route(11'h7ff, shared_mac_slot[0], 1'b1);
    route(11'h008, shared_mac_slot[3], 1'b1);
    reg_op(1'b1, `REG_V4_LO, 16'h0201);
    reg_op(1'b1, `REG_V4_HI, 16'h0403);
    rd_chk(`REG_V4_HI, 16'h0403);
    m = '0;
    m.is_arp = 1'b1;
    m.v4_dst = 32'h0403_0201;
    u_rx_source.send(m);
    chk({30'h0, v4m}, 32'h2, "arp");
    m.is_arp = 1'b0;
    m.is_ipv4 = 1'b1;
    u_rx_source.send(m);
    chk({30'h0, v4m}, 32'h1, "wake");
    m.v4_dst = 32'h0102_0304;
    u_rx_source.send(m);
    chk({31'h0, verdict.v4_wake_match}, 32'h0, "order");
    @(negedge ref_clk);
    chk({31'h0, verdict.valid}, 32'h0, "idle");
    arst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    arst_n = 1'b1;
    rd_chk(`REG_BIND_HI, 16'h0);
    rd_chk(`REG_SHR_EN, 16'h0);
    summarize();
  end
endmodule
`default_nettype wire
